// ---- design/msc_pkg.sv ----
package msc_pkg;

  // Decoded microinstruction operations
  typedef enum logic [3:0] {
    OP_CONT = 4'h0,
    OP_HOLD = 4'h1,
    OP_JABS = 4'h2,
    OP_JREL = 4'h3,
    OP_CALL = 4'h4,
    OP_RET = 4'h5,
    OP_JREG = 4'h6,
    OP_PUSHR = 4'h7,
    OP_POPR = 4'h8,
    OP_JIND = 4'h9,
    OP_DEC = 4'ha,
    OP_CLRI = 4'hb
  } msc_op_e;

  // Clock high and clock low halves of one instruction cycle
  typedef enum logic {
    PH_HI = 1'b0,
    PH_LO = 1'b1
  } msc_phase_e;

  // Register port word offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_BOUND = 4'h1;
  localparam logic [3:0] REG_VPTR = 4'h2;
  localparam logic [3:0] REG_VDATA = 4'h3;
  localparam logic [3:0] REG_SSP = 4'h4;
  localparam logic [3:0] REG_LSP = 4'h5;
  localparam logic [3:0] REG_GSP = 4'h6;
  localparam logic [3:0] REG_PC = 4'h7;
  localparam logic [3:0] REG_CNT0 = 4'h8;
  localparam logic [3:0] REG_CNT1 = 4'h9;
  localparam logic [3:0] REG_CNT2 = 4'ha;
  localparam logic [3:0] REG_CNT3 = 4'hb;
  localparam logic [3:0] REG_PEND = 4'hc;
  localparam logic [3:0] REG_POPD = 4'hd;

  // Status bit positions
  localparam int unsigned SR_TRANSP = 0;
  localparam int unsigned SR_SIGN = 1;
  localparam int unsigned SR_IE = 2;
  localparam int unsigned SR_GSEL = 3;
  localparam int unsigned SR_WID_LO = 4;
  localparam int unsigned SR_MASK_LO = 6;

  // Offset width codes in the status width field
  localparam logic [1:0] WID_8 = 2'h0;
  localparam logic [1:0] WID_12 = 2'h1;

  // Reset values and sizes
  localparam logic [15:0] SR_RESET = 16'h0000;
  localparam logic [5:0] SSP_RESET = 6'h00;
  localparam logic [5:0] RSP_BOTTOM = 6'h3f;
  localparam int unsigned RAM_WORDS = 64;
  localparam int unsigned NUM_VEC = 10;
  localparam int unsigned NUM_CNT = 4;
  localparam int unsigned IRQ_CNT = 0;
  localparam int unsigned IRQ_STACK = 9;

  // Sign-extends a data port offset to the selected width
  function automatic logic [15:0] sext_offset(input logic [15:0] d,
                                              input logic [1:0] w);
    logic [15:0] r;
    r = d;
    if (w == WID_8)
    begin
      r = {{8{d[7]}}, d[7:0]};
    end
    else if (w == WID_12)
    begin
      r = {{4{d[11]}}, d[11:0]};
    end
    return r;
  endfunction

  // Index of the highest-numbered set request
  function automatic logic [3:0] prio_index(input logic [9:0] req);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 10; i++)
    begin
      if (req[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

endpackage

// ---- design/msc_ram.sv ----
`timescale 1ns/1ps
module msc_ram
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Write port
  input wire logic we_i,
  input wire logic [5:0] waddr_i,
  input wire logic [15:0] wdata_i,
  // Read port, data one cycle later
  input wire logic [5:0] raddr_i,
  output logic [15:0] rdata_o
);

  logic [15:0] mem [RAM_WORDS];
  logic [15:0] rdata_ff;

  // Storage array, no reset
  always_ff @(posedge clock_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read data
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rdata_ff <= mem[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;

endmodule

// ---- design/msc_core.sv ----
`timescale 1ns/1ps
module msc_core
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Decoded microinstruction, held for a whole instruction cycle
  input wire msc_op_e op_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic [1:0] cnt_sel_i,
  input wire logic [15:0] data_i,
  // External interrupt pins
  input wire logic [3:0] external_interrupt_pins_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Microcode address and conditions
  output logic [15:0] addr_o,
  output logic phase_lo_o,
  output logic [3:0] cnt_sign_o,
  output logic sign_o
);

  msc_phase_e phase_ff, nxt_phase;
  logic [15:0] pc_ff, nxt_pc;
  logic [15:0] addr_ff, nxt_addr;
  logic [15:0] status_bits_ff, nxt_status_bits;
  logic [3:0] stack_boundary_register_ff, nxt_stack_boundary_register;
  logic [3:0] vector_file_pointer_ff, nxt_vector_file_pointer;
  logic [15:0] vec_ff [NUM_VEC];
  logic [15:0] nxt_vec [NUM_VEC];
  logic [15:0] cnt_ff [NUM_CNT];
  logic [15:0] nxt_cnt [NUM_CNT];
  logic [5:0] subroutine_stack_pointer_ff, nxt_subroutine_stack_pointer;
  logic [5:0] local_stack_pointer_ff, nxt_local_stack_pointer;
  logic [5:0] global_stack_pointer_ff, nxt_global_stack_pointer;
  logic [7:0] ext_raw_ff, nxt_ext_raw;
  logic [7:0] ext_latch_ff, nxt_ext_latch;
  logic [1:0] int_pend_ff, nxt_int_pend;
  logic [15:0] pop_data_ff, nxt_pop_data;
  logic [15:0] rdata_ff, nxt_rdata;

  logic ex;
  logic [5:0] rsp;
  logic [5:0] limit;
  logic [5:0] ram_raddr;
  logic [15:0] ram_rdata;
  logic ram_we;
  logic [5:0] ram_waddr;
  logic [15:0] ram_wdata;
  logic [15:0] off_ext;
  logic [9:0] internal_interrupt_request;
  logic [9:0] eff;
  logic [3:0] idx;
  logic take;
  logic [15:0] vec_sel;

  // Phase, stack selection, request gating
  assign ex = (phase_ff == PH_LO);
  assign rsp = status_bits_ff[SR_GSEL] ? global_stack_pointer_ff
                                       : local_stack_pointer_ff;
  assign limit = {stack_boundary_register_ff, 2'b00};
  assign off_ext = sext_offset(data_i,
                     status_bits_ff[SR_WID_LO+1:SR_WID_LO]);
  assign internal_interrupt_request = {int_pend_ff[1],
    status_bits_ff[SR_TRANSP] ? ext_raw_ff : ext_latch_ff,
    int_pend_ff[0]};
  assign eff = internal_interrupt_request
             & ~status_bits_ff[15:SR_MASK_LO]
             & {10{status_bits_ff[SR_IE]}};
  assign idx = prio_index(eff);
  assign vec_sel = vec_ff[idx];
  assign take = ex && (|eff) && (op_i != OP_CALL) && (op_i != OP_PUSHR);

  // RAM read address, issued in clock high
  always_comb
  begin
    unique case (op_i)
      OP_RET: ram_raddr = subroutine_stack_pointer_ff;
      OP_JREG, OP_POPR: ram_raddr = rsp + {4'h0, reg_sel_i};
      OP_JIND: ram_raddr = data_i[5:0];
      default: ram_raddr = subroutine_stack_pointer_ff;
    endcase
  end

  // Shared stack and table memory
  msc_ram u_ram (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .we_i(ram_we),
    .waddr_i(ram_waddr),
    .wdata_i(ram_wdata),
    .raddr_i(ram_raddr),
    .rdata_o(ram_rdata)
  );

  // Next state of the whole sequencer
  always_comb
  begin
    logic [15:0] target;
    logic hold, push_sub, pop_sub, push_reg, pop_reg;
    logic [5:0] ssp_popped, sub_new, rsp_new;
    target = pc_ff;
    hold = 1'b0;
    push_sub = 1'b0;
    pop_sub = 1'b0;
    push_reg = 1'b0;
    pop_reg = 1'b0;
    ssp_popped = subroutine_stack_pointer_ff;
    sub_new = subroutine_stack_pointer_ff;
    rsp_new = rsp;
    nxt_phase = (phase_ff == PH_HI) ? PH_LO : PH_HI;
    nxt_pc = pc_ff;
    nxt_addr = addr_ff;
    nxt_status_bits = status_bits_ff;
    nxt_stack_boundary_register = stack_boundary_register_ff;
    nxt_vector_file_pointer = vector_file_pointer_ff;
    nxt_vec = vec_ff;
    nxt_cnt = cnt_ff;
    nxt_subroutine_stack_pointer = subroutine_stack_pointer_ff;
    nxt_local_stack_pointer = local_stack_pointer_ff;
    nxt_global_stack_pointer = global_stack_pointer_ff;
    nxt_ext_raw = ext_raw_ff;
    nxt_ext_latch = ext_latch_ff;
    nxt_int_pend = int_pend_ff;
    nxt_pop_data = pop_data_ff;
    ram_we = 1'b0;
    ram_waddr = subroutine_stack_pointer_ff;
    ram_wdata = pc_ff;
    // Register port writes; hardware updates below take precedence
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        REG_STATUS: nxt_status_bits = reg_wdata_i;
        REG_BOUND: nxt_stack_boundary_register = reg_wdata_i[3:0];
        REG_VPTR: nxt_vector_file_pointer = reg_wdata_i[3:0];
        REG_VDATA:
        begin
          if (vector_file_pointer_ff < 4'(NUM_VEC))
          begin
            nxt_vec[vector_file_pointer_ff] = reg_wdata_i;
          end
        end
        REG_SSP: nxt_subroutine_stack_pointer = reg_wdata_i[5:0];
        REG_LSP: nxt_local_stack_pointer = reg_wdata_i[5:0];
        REG_GSP: nxt_global_stack_pointer = reg_wdata_i[5:0];
        REG_CNT0, REG_CNT1, REG_CNT2, REG_CNT3:
          nxt_cnt[reg_addr_i[1:0]] = reg_wdata_i;
        default: ;
      endcase
    end
    // Instruction clears of pending requests, before new captures
    if (ex && (op_i == OP_CLRI))
    begin
      nxt_ext_latch = nxt_ext_latch & ~data_i[8:1];
      nxt_int_pend = nxt_int_pend & ~{data_i[IRQ_STACK], data_i[IRQ_CNT]};
    end
    // Pin capture: upper four in clock high, lower four in clock low
    if (phase_ff == PH_HI)
    begin
      nxt_ext_raw[7:4] = external_interrupt_pins_i;
      if (!status_bits_ff[SR_TRANSP])
      begin
        nxt_ext_latch[7:4] = nxt_ext_latch[7:4]
                           | external_interrupt_pins_i;
      end
    end
    else
    begin
      nxt_ext_raw[3:0] = external_interrupt_pins_i;
      if (!status_bits_ff[SR_TRANSP])
      begin
        nxt_ext_latch[3:0] = nxt_ext_latch[3:0]
                           | external_interrupt_pins_i;
      end
    end
    // Instruction execution at the end of clock low
    if (ex)
    begin
      unique case (op_i)
        OP_CONT: target = pc_ff;
        OP_HOLD:
        begin
          target = addr_ff;
          hold = 1'b1;
        end
        OP_JABS: target = data_i;
        OP_JREL: target = pc_ff + off_ext;
        OP_CALL:
        begin
          target = data_i;
          push_sub = 1'b1;
        end
        OP_RET:
        begin
          target = ram_rdata;
          pop_sub = 1'b1;
        end
        OP_JREG: target = ram_rdata;
        OP_PUSHR: push_reg = 1'b1;
        OP_POPR:
        begin
          pop_reg = 1'b1;
          nxt_pop_data = ram_rdata;
        end
        OP_JIND: target = ram_rdata;
        OP_DEC:
        begin
          nxt_cnt[cnt_sel_i] = cnt_ff[cnt_sel_i] - 16'h0001;
          nxt_status_bits[SR_SIGN] = cnt_ff[cnt_sel_i][15];
          if (!cnt_ff[cnt_sel_i][15] && nxt_cnt[cnt_sel_i][15])
          begin
            nxt_int_pend[0] = 1'b1;
          end
        end
        OP_CLRI: target = pc_ff;
        default: target = pc_ff;
      endcase
      // Subroutine stack: return address for calls and interrupts
      ram_wdata = push_sub ? pc_ff : data_i;
      if (take)
      begin
        push_sub = 1'b1;
        ram_wdata = target;
      end
      ssp_popped = pop_sub ? subroutine_stack_pointer_ff - 6'h01
                           : subroutine_stack_pointer_ff;
      sub_new = push_sub ? ssp_popped + 6'h01 : ssp_popped;
      nxt_subroutine_stack_pointer = sub_new;
      if ((pop_sub && (subroutine_stack_pointer_ff == 6'h00))
          || (push_sub && (sub_new >= limit)))
      begin
        nxt_int_pend[1] = 1'b1;
      end
      // Register stack: grows downward
      rsp_new = rsp;
      if (push_reg)
      begin
        rsp_new = rsp - 6'h01;
        if (rsp_new < limit)
        begin
          nxt_int_pend[1] = 1'b1;
        end
      end
      else if (pop_reg)
      begin
        rsp_new = rsp + 6'h01;
        if (rsp == RSP_BOTTOM)
        begin
          nxt_int_pend[1] = 1'b1;
        end
      end
      if (status_bits_ff[SR_GSEL])
      begin
        nxt_global_stack_pointer = rsp_new;
      end
      else
      begin
        nxt_local_stack_pointer = rsp_new;
      end
      ram_we = push_sub || push_reg;
      ram_waddr = push_sub ? sub_new : rsp_new;
      // Address port and program counter
      if (take)
      begin
        nxt_addr = vec_sel;
        nxt_pc = vec_sel + 16'h0001;
        nxt_status_bits[SR_IE] = 1'b0;
      end
      else if (!hold)
      begin
        nxt_addr = target;
        nxt_pc = target + 16'h0001;
      end
    end
  end

  // Register port read data, valid only in the cycle after the strobe
  always_comb
  begin
    nxt_rdata = 16'h0000;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        REG_STATUS: nxt_rdata = status_bits_ff;
        REG_BOUND: nxt_rdata = {12'h000, stack_boundary_register_ff};
        REG_VPTR: nxt_rdata = {12'h000, vector_file_pointer_ff};
        REG_VDATA: nxt_rdata = (vector_file_pointer_ff < 4'(NUM_VEC))
                             ? vec_ff[vector_file_pointer_ff] : 16'h0000;
        REG_SSP: nxt_rdata = {10'h000, subroutine_stack_pointer_ff};
        REG_LSP: nxt_rdata = {10'h000, local_stack_pointer_ff};
        REG_GSP: nxt_rdata = {10'h000, global_stack_pointer_ff};
        REG_PC: nxt_rdata = pc_ff;
        REG_CNT0, REG_CNT1, REG_CNT2, REG_CNT3:
          nxt_rdata = cnt_ff[reg_addr_i[1:0]];
        REG_PEND: nxt_rdata = {6'h00, internal_interrupt_request};
        REG_POPD: nxt_rdata = pop_data_ff;
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  // Registers with reset
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase_ff <= PH_HI;
      pc_ff <= 16'h0001;
      addr_ff <= 16'h0000;
      status_bits_ff <= SR_RESET;
      stack_boundary_register_ff <= 4'h0;
      vector_file_pointer_ff <= 4'h0;
      vec_ff <= '{default: 16'h0000};
      cnt_ff <= '{default: 16'h0000};
      subroutine_stack_pointer_ff <= SSP_RESET;
      ext_raw_ff <= 8'h00;
      ext_latch_ff <= 8'h00;
      int_pend_ff <= 2'h0;
      pop_data_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
    end
    else
    begin
      phase_ff <= nxt_phase;
      pc_ff <= nxt_pc;
      addr_ff <= nxt_addr;
      status_bits_ff <= nxt_status_bits;
      stack_boundary_register_ff <= nxt_stack_boundary_register;
      vector_file_pointer_ff <= nxt_vector_file_pointer;
      vec_ff <= nxt_vec;
      cnt_ff <= nxt_cnt;
      subroutine_stack_pointer_ff <= nxt_subroutine_stack_pointer;
      ext_raw_ff <= nxt_ext_raw;
      ext_latch_ff <= nxt_ext_latch;
      int_pend_ff <= nxt_int_pend;
      pop_data_ff <= nxt_pop_data;
      rdata_ff <= nxt_rdata;
    end
  end

  // Register stack pointers survive reset
  always_ff @(posedge clock_i)
  begin
    local_stack_pointer_ff <= nxt_local_stack_pointer;
    global_stack_pointer_ff <= nxt_global_stack_pointer;
  end

  // Outputs
  assign reg_rdata_o = rdata_ff;
  assign addr_o = addr_ff;
  assign phase_lo_o = (phase_ff == PH_LO);
  assign sign_o = status_bits_ff[SR_SIGN];
  always_comb
  begin
    for (int i = 0; i < NUM_CNT; i++)
    begin
      cnt_sign_o[i] = cnt_ff[i][15];
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_pc_step: assert property (ex && op_i == OP_CONT && !take |=>
    addr_ff == $past(pc_ff) && pc_ff == $past(pc_ff) + 16'h0001)
    else $error("sequential step did not advance the counter");
  a_pc_hold: assert property (ex && op_i == OP_HOLD && !take |=>
    pc_ff == $past(pc_ff) && addr_ff == $past(addr_ff))
    else $error("held instruction moved the counter");
  a_jump_abs: assert property (ex && op_i == OP_JABS && !take |=>
    addr_ff == $past(data_i) && pc_ff == $past(data_i) + 16'h0001)
    else $error("absolute jump target wrong");
  a_jump_rel: assert property (ex && op_i == OP_JREL && !take |=>
    addr_ff == $past(pc_ff) + $past(off_ext))
    else $error("relative jump target wrong");
  a_offset_width: assert property (
    status_bits_ff[5:4] == WID_8 |-> off_ext == {{8{data_i[7]}}, data_i[7:0]})
    else $error("8-bit offset not sign-extended");
  a_sub_push: assert property (ex && op_i == OP_CALL |=>
    subroutine_stack_pointer_ff == $past(subroutine_stack_pointer_ff) + 6'h01)
    else $error("call did not raise the subroutine pointer");
  a_local_push: assert property (
    ex && op_i == OP_PUSHR && !status_bits_ff[SR_GSEL] |=>
    local_stack_pointer_ff == $past(local_stack_pointer_ff) - 6'h01)
    else $error("push did not lower the local pointer");
  a_vector_out: assert property (take |=> addr_ff == $past(vec_sel))
    else $error("vector not driven after recognition");
  a_dec_sign: assert property (ex && op_i == OP_DEC |=>
    sign_o == $past(cnt_ff[cnt_sel_i][15]))
    else $error("sign bit not copied before decrement");
  a_latch_keep: assert property (
    ext_latch_ff[7] && !(ex && op_i == OP_CLRI) |=> ext_latch_ff[7])
    else $error("latched request lost without a clear");
  a_stack_ovf: assert property (ex && op_i == OP_CALL &&
    subroutine_stack_pointer_ff + 6'h01 >= limit |=> int_pend_ff[1])
    else $error("stack overflow did not raise interrupt 9");

endmodule

// ---- sim/msc_irq_src.sv ----
`timescale 1ns/1ps
// Interrupt sources that share four pins across the two clock halves
module msc_irq_src
(
  // Sequencer phase
  input wire logic phase_lo_i,
  // Requests, bit 7 is the highest external interrupt
  input wire logic [7:0] req_i,
  // Shared pins
  output logic [3:0] pins_o
);
  // Upper four requests in clock high, lower four in clock low
  assign pins_o = phase_lo_i ? req_i[3:0] : req_i[7:4];
endmodule

// ---- sim/microprogram_sequencer_core_test.sv ----
`timescale 1ns/1ps
module microprogram_sequencer_core_test
  import msc_pkg::*;
;
  // Stimulus, observed outputs and model state
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  msc_op_e op_i = OP_HOLD;
  logic [1:0] sel = 2'h0;
  logic [15:0] data_i = 16'h0000;
  logic [7:0] req = 8'h00;
  logic [3:0] pins;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic [15:0] addr_o;
  logic phase_lo_o;
  logic sign_o;
  logic [3:0] cnt_sign_o;
  logic [15:0] rnd = 16'h005f;
  logic [15:0] vec;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int pc, ea, subroutine_stack_pointer, rsp, popd, wid, cnt, old;
  int ram [64];

  msc_core u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .op_i(op_i),
    .reg_sel_i(sel), .cnt_sel_i(sel), .data_i(data_i),
    .external_interrupt_pins_i(pins), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .addr_o(addr_o), .phase_lo_o(phase_lo_o),
    .cnt_sign_o(cnt_sign_o), .sign_o(sign_o));
  msc_irq_src u_src (.phase_lo_i(phase_lo_o), .req_i(req), .pins_o(pins));

  // Clock and a cycle ceiling against hangs
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Sign extension of an offset at the selected width
  function automatic int sx(input int d);
    if (wid == 0)
      return (d & 255) - ((d & 128) << 1);
    if (wid == 1)
      return (d & 4095) - ((d & 2048) << 1);
    return d & 65535;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rst();
    resetn_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    pc = 1;
    subroutine_stack_pointer = 0;
  endtask

  // Register port cycles, two clocks each to keep the instruction phase
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata_o);
    @(posedge clock_i);
  endtask

  // One instruction cycle, with the model of its next address
  task automatic ex(input msc_op_e o, input int d, input int s);
    op_i <= o;
    data_i <= d[15:0];
    sel <= s[1:0];
    @(posedge clock_i);
    #1 chk("phase_lo_o", 16'h0001, 16'(phase_lo_o));
    @(posedge clock_i);
    op_i <= OP_HOLD;
    ea = pc;
    case (o)
      OP_HOLD: ea = pc - 1;
      OP_JABS: ea = d;
      OP_JREL: ea = pc + sx(d);
      OP_CALL:
      begin
        subroutine_stack_pointer++;
        ram[subroutine_stack_pointer] = pc;
        ea = d;
      end
      OP_RET:
      begin
        ea = ram[subroutine_stack_pointer];
        subroutine_stack_pointer--;
      end
      OP_JREG: ea = ram[rsp + s];
      OP_PUSHR:
      begin
        rsp--;
        ram[rsp] = d;
      end
      OP_POPR:
      begin
        popd = ram[rsp + s];
        rsp++;
      end
      OP_JIND: ea = ram[d & 63];
      default: ;
    endcase
    ea = ea & 65535;
    pc = (ea + 1) & 65535;
    #1 chk("addr_o", ea[15:0], addr_o);
  endtask

  task automatic finish_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst();
    chk("addr_o", 16'h0000, addr_o);
    chk("phase_lo_o", 16'h0000, 16'(phase_lo_o));
    rd(REG_SSP, 16'h0000);
    rd(REG_STATUS, 16'h0000);
    wr(REG_BOUND, 16'h0008);
    rd(REG_BOUND, 16'h0008);
    rd(4'he, 16'h0000);
    wr(REG_LSP, 16'h0030);
    rsp = 48;
    repeat (3) ex(OP_CONT, 0, 0);
    ex(OP_HOLD, 0, 0);
    rd(REG_PC, 16'(pc));
    ex(OP_JABS, 16'hfffe, 0);
    repeat (2) ex(OP_CONT, 0, 0);
    for (wid = 0; wid < 3; wid++)
    begin
      wr(REG_STATUS, 16'(wid << 4));
      rnd = lfsr(rnd);
      ex(OP_JREL, rnd & 16'h7777, 0);
      ex(OP_JREL, rnd | 16'h8880, 0);
    end
    ex(OP_CALL, 16'h1234, 0);
    ex(OP_CALL, 16'h2345, 0);
    rd(REG_SSP, 16'h0002);
    repeat (2) ex(OP_RET, 0, 0);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      ex(OP_PUSHR, rnd, 0);
    end
    rd(REG_LSP, 16'h002c);
    for (int i = 0; i < 4; i++)
      ex(OP_JREG, 0, i);
    ex(OP_JIND, 16'hffee, 0);
    ex(OP_POPR, 0, 1);
    rd(REG_POPD, 16'(popd));
    wr(REG_GSP, 16'h003f);
    wr(REG_STATUS, 16'h0008);
    rsp = 63;
    ex(OP_POPR, 0, 0);
    rsp = 45;
    rd(REG_GSP, 16'h0000);
    rd(REG_LSP, 16'h002d);
    rd(REG_PEND, 16'h0200);
    ex(OP_CLRI, 16'h03ff, 0);
    rd(REG_PEND, 16'h0000);
    wr(REG_STATUS, 16'h0000);
    cnt = 1;
    wr(REG_CNT2, 16'(cnt));
    for (int i = 0; i < 3; i++)
    begin
      old = (cnt >> 15) & 1;
      ex(OP_DEC, 0, 2);
      cnt = (cnt - 1) & 65535;
      chk("sign_o", 16'(old), 16'(sign_o));
      chk("cnt_sign_o", 16'((cnt >> 15) << 2), 16'(cnt_sign_o));
    end
    rd(REG_CNT2, 16'(cnt));
    rd(REG_PEND, 16'h0001);
    ex(OP_CLRI, 16'h0001, 0);
    rnd = lfsr(rnd);
    vec = rnd;
    wr(REG_VPTR, 16'h0005);
    wr(REG_VDATA, vec);
    rd(REG_VDATA, vec);
    wr(REG_VPTR, 16'h000a);
    rd(REG_VDATA, 16'h0000);
    req <= 8'h10;
    ex(OP_CONT, 0, 0);
    req <= 8'h00;
    rd(REG_PEND, 16'h0020);
    wr(REG_STATUS, 16'h0804);
    ex(OP_CONT, 0, 0);
    wr(REG_STATUS, 16'h0004);
    pc = (vec + 1) & 65535;
    subroutine_stack_pointer++;
    #1 chk("addr_o", vec, addr_o);
    rd(REG_STATUS, 16'h0000);
    ex(OP_CONT, 0, 0);
    ex(OP_CLRI, 16'h0020, 0);
    rd(REG_PEND, 16'h0000);
    wr(REG_STATUS, 16'h0001);
    req <= 8'h80;
    ex(OP_CONT, 0, 0);
    rd(REG_PEND, 16'h0100);
    req <= 8'h00;
    ex(OP_CONT, 0, 0);
    rd(REG_PEND, 16'h0000);
    wr(REG_BOUND, 16'h0000);
    ex(OP_CALL, 16'h0100, 0);
    rd(REG_SSP, 16'(subroutine_stack_pointer));
    rd(REG_PEND, 16'h0200);
    rst();
    rd(REG_SSP, 16'h0000);
    rd(REG_LSP, 16'(rsp));
    finish_test();
  end
endmodule
